// >>> shared/ets_map.svh
// Purpose: Constants for the error and thermal signalling block
// Assumes: Counts are in bus-clock cycles
// Notes:   Included by the package and the design files
`ifndef ETS_MAP_SVH
`define ETS_MAP_SVH
`define ETS_MC_PULSE_CYCLES 16
`define ETS_CNT_W           5
`define ETS_CNT_ONE         5'h01
`define ETS_CNT_ZERO        5'h00
`endif

// >>> shared/ets_pkg.sv
// Purpose: Types for the error and thermal signalling block
// Assumes: Constants come from ets_map.svh
// Notes:   Holds the state machine and state record types
`include "ets_map.svh"
package ets_pkg;
    // Fatal error output states, one-hot
    typedef enum logic [2:0] {
        ETS_ERR_IDLE  = 3'b001,
        ETS_ERR_PULSE = 3'b010,
        ETS_ERR_HOLD  = 3'b100
    } ets_err_state_type;

    typedef struct packed {
        ets_err_state_type          err_st;
        logic [`ETS_CNT_W-1:0]      cnt;
        logic                       shutdown;
        logic                       regfault;
    } ets_state_type;
endpackage

// >>> hw/ets_pulse_timer.sv
// Purpose: Down counter that times the fatal error pulse
// Assumes: Start and count load in one cycle
// Notes:   Done is high in the last cycle of the window
`timescale 1ns/1ps
`include "ets_map.svh"
module ets_pulse_timer #(
    parameter int CNT_W = `ETS_CNT_W
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    // Control
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_len,
    // Status
    output logic                  o_busy,
    output logic                  o_done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } ets_tmr_state_type;

    ets_tmr_state_type st_r;
    ets_tmr_state_type st_nxt;

    // Load on start, otherwise count down to zero
    always_comb begin
        st_nxt = st_r;
        if (i_start) begin
            st_nxt.cnt = i_len;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - CNT_W'(1);
        end
    end

    // Count register; reset leaves the timer idle
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_busy = (st_r.cnt != '0);
    assign o_done = (st_r.cnt == CNT_W'(1));
endmodule

// >>> hw/ets_signal_core.sv
// Purpose: Fatal error, overheat and thermal shutdown pin logic
// Assumes: All inputs synchronous to i_clk_sys; reset covers warm and cold reset
// Notes:   Overheat pin is open drain; enable low means the pin is pulled low
//          Fatal error pulse length is set by a timer and cross-checked by a run counter
//          Every sticky flag is cleared only by the reset input
`timescale 1ns/1ps
`include "ets_map.svh"

// Function
// - Machine check fault pulses fatal_error_n low for exactly 16 clocks.
// - Internal fault holds fatal_error_n low until warm or cold reset.
// - Drive overheat_n low whenever sensor says maximum safe temperature reached.
// - Overheat assertion coincides with throttle circuit activation when enabled.
// - External low on overheat_n activates the throttle circuit likewise.
// - Trip comparator above shutdown threshold halts execution, asserts thermal_shutdown_n.
// - Regulator fault asserts regulator_fault output with thermal shutdown, shuts down.
module ets_signal_core #(
    parameter int MC_PULSE = `ETS_MC_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    // Internal error sources
    input  wire logic i_machine_check_fault,
    input  wire logic i_internal_fault,
    input  wire logic i_power_fault,
    // Thermal sensing and control
    input  wire logic i_temp_max_reached,
    input  wire logic i_trip_over_limit,
    input  wire logic i_throttle_enable,
    // Overheat open-drain pin
    input  wire logic i_overheat_n,
    output logic      o_overheat_n,
    output logic      o_overheat_oe_n,
    // Error and shutdown pins
    output logic      o_fatal_error_n,
    output logic      o_thermal_shutdown_n,
    output logic      o_regulator_fault,
    // Internal controls
    output logic      o_thermal_throttle_circuit,
    output logic      o_halt_execution
);
    // State record and its next value
    ets_pkg::ets_state_type st_r;
    ets_pkg::ets_state_type st_nxt;
    // Timer handshake
    logic                   tmr_start;
    logic                   tmr_busy;
    logic                   tmr_done;
    // Decoded error state, shared by the pin and the checks
    logic                   err_idle;
    logic                   err_pulse;
    logic                   err_hold;

    // Pulse length timer; its busy flag is cross-checked below
    ets_pulse_timer #(.CNT_W(`ETS_CNT_W)) ets_pulse_timer_i (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_start   (tmr_start),
        .i_len     (`ETS_CNT_W'(MC_PULSE)),
        .o_busy    (tmr_busy),
        .o_done    (tmr_done)
    );

    // Error state machine; internal fault outranks a running pulse
    always_comb begin
        st_nxt    = st_r;
        tmr_start = 1'b0;
        case (st_r.err_st)
            ets_pkg::ETS_ERR_IDLE: begin
                // Internal fault wins over a machine check in the same cycle
                if (i_internal_fault) begin
                    st_nxt.err_st = ets_pkg::ETS_ERR_HOLD;
                end else if (i_machine_check_fault) begin
                    st_nxt.err_st = ets_pkg::ETS_ERR_PULSE;
                    tmr_start     = 1'b1;
                end
            end
            ets_pkg::ETS_ERR_PULSE: begin
                // A machine check here is ignored, never a retrigger
                if (i_internal_fault) begin
                    st_nxt.err_st = ets_pkg::ETS_ERR_HOLD;
                end else if (tmr_done) begin
                    st_nxt.err_st = ets_pkg::ETS_ERR_IDLE;
                end
            end
            ets_pkg::ETS_ERR_HOLD: begin
                // Only the reset input leaves this state
                st_nxt.err_st = ets_pkg::ETS_ERR_HOLD;
            end
            default: begin
                st_nxt.err_st = ets_pkg::ETS_ERR_IDLE;
            end
        endcase
        // Shutdown and regulator flags stick until reset
        if (i_trip_over_limit || i_power_fault) begin
            st_nxt.shutdown = 1'b1;
        end
        if (i_power_fault) begin
            st_nxt.regfault = 1'b1;
        end

        // Run counter of low cycles in the pulse, kept apart from the timer
        // so that a fault in either one shows up as a length mismatch
        if (st_nxt.err_st == ets_pkg::ETS_ERR_PULSE) begin
            if (st_r.err_st == ets_pkg::ETS_ERR_PULSE) begin
                st_nxt.cnt = st_r.cnt + `ETS_CNT_ONE;
            end else begin
                st_nxt.cnt = `ETS_CNT_ONE;
            end
        end else begin
            st_nxt.cnt = `ETS_CNT_ZERO;
        end
    end

    // State register; warm and cold reset both clear it
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r.err_st   <= ets_pkg::ETS_ERR_IDLE;
            st_r.cnt      <= `ETS_CNT_ZERO;
            st_r.shutdown <= 1'b0;
            st_r.regfault <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Decoded error state
    assign err_idle  = (st_r.err_st == ets_pkg::ETS_ERR_IDLE);
    assign err_pulse = (st_r.err_st == ets_pkg::ETS_ERR_PULSE);
    assign err_hold  = (st_r.err_st == ets_pkg::ETS_ERR_HOLD);

    // Pin outputs; state is registered, overheat is combinational to follow the sensor
    assign o_fatal_error_n      = err_idle;
    assign o_thermal_shutdown_n = ~st_r.shutdown;
    assign o_regulator_fault    = st_r.regfault;
    assign o_halt_execution     = st_r.shutdown;
    // Open drain: data stays low, the enable alone pulls the wire
    // Sensor level is not latched, so cooling releases the wire at once
    assign o_overheat_n         = 1'b0;
    assign o_overheat_oe_n      = ~i_temp_max_reached;
    // Throttle on own sensor or external pull, only when enabled
    assign o_thermal_throttle_circuit = i_throttle_enable &&
        (i_temp_max_reached || !i_overheat_n);

    // Checks: fatal error pulse length, measured by the run counter
    a_mc_pulse_len: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_fatal_error_n) |-> ($past(st_r.cnt) == `ETS_CNT_W'(MC_PULSE)))
        else $error("fatal error pulse length wrong");
    a_mc_pulse_max: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        err_pulse |-> (st_r.cnt <= `ETS_CNT_W'(MC_PULSE)))
        else $error("fatal error pulse runs too long");
    a_mc_pulse_start: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (err_idle && i_machine_check_fault && !i_internal_fault) |=> (err_pulse && (st_r.cnt == `ETS_CNT_ONE)))
        else $error("fatal error pulse did not start");
    a_mc_timer_run: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        err_pulse |-> tmr_busy)
        else $error("pulse timer idle during pulse");

    // Checks: internal fault hold and its priority
    a_fault_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        i_internal_fault |=> !o_fatal_error_n [*8])
        else $error("fatal error not held after internal fault");
    a_fault_first: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (err_idle && i_internal_fault && i_machine_check_fault) |=> err_hold)
        else $error("machine check beat internal fault");
    a_fault_in_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (err_pulse && i_internal_fault) |=> err_hold)
        else $error("internal fault lost during pulse");
    a_fault_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        err_hold |=> !o_fatal_error_n)
        else $error("fatal error released before reset");

    // Checks: overheat pin and throttle circuit
    a_hot_drive: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        i_temp_max_reached |-> (!o_overheat_oe_n && !o_overheat_n))
        else $error("overheat pin not driven");
    a_throttle_coin: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_throttle_enable && !o_overheat_oe_n) |-> o_thermal_throttle_circuit)
        else $error("throttle not active with overheat");
    a_ext_throttle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_throttle_enable && !i_overheat_n) |-> o_thermal_throttle_circuit)
        else $error("external overheat ignored");

    // Checks: trip, regulator fault, shutdown latch, and overheat and throttle release
    a_trip_latch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        i_trip_over_limit |=> (!o_thermal_shutdown_n && o_halt_execution))
        else $error("thermal shutdown not asserted");
    a_vr_fault: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        i_power_fault |=> (o_regulator_fault && !o_thermal_shutdown_n))
        else $error("regulator fault not signalled");
    a_trip_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !o_thermal_shutdown_n |=> !o_thermal_shutdown_n)
        else $error("thermal shutdown released");
    a_hot_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_temp_max_reached |-> o_overheat_oe_n)
        else $error("overheat latched");
    a_hot_release: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!i_temp_max_reached && i_overheat_n) |-> !o_thermal_throttle_circuit)
        else $error("throttle latched after overheat");
    a_hot_ext_only: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_throttle_enable |-> !o_thermal_throttle_circuit)
        else $error("throttle active while disabled");

    // Checks: regulator flag pairs with shutdown and sticks
    a_reg_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_regulator_fault |=> o_regulator_fault)
        else $error("regulator fault released");
    a_reg_with_trip: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_regulator_fault |-> !o_thermal_shutdown_n)
        else $error("regulator fault without shutdown");
    a_reg_only_power: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_regulator_fault) |-> $past(i_power_fault))
        else $error("regulator fault without power fault");

    // Main scenarios
    c_mc_pulse: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $fell(o_fatal_error_n) ##16 $rose(o_fatal_error_n));
    c_fault_hold: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        i_internal_fault ##1 !o_fatal_error_n);
    c_fault_first: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        err_idle && i_internal_fault && i_machine_check_fault);
    c_trip: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $fell(o_thermal_shutdown_n));
    c_ext_hot: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_overheat_n && o_overheat_oe_n && o_thermal_throttle_circuit);
endmodule

// >>> testbench/ets_platform_model.sv
// Purpose: Platform side of the overheat open-drain wire
// Assumes: The wire has a pull-up on the board
// Notes:   Resolves the wire level from every party's drive
`timescale 1ns/1ps
module ets_platform_model (
    // Device side of the pin
    input  wire logic i_dev_data,
    input  wire logic i_dev_oe_n,
    // Platform request to assert overheat
    input  wire logic i_force_hot,
    // Resolved wire level
    output logic      o_wire_n
);
    // Pull-up wins unless someone sinks the line, so the wire is never left unknown
    assign o_wire_n = ((!i_dev_oe_n && !i_dev_data) || i_force_hot) ? 1'h0 : 1'h1;
endmodule

// >>> testbench/ets_signal_core_tb.sv
// Purpose: Self-checking bench for the error and thermal pin logic
// Assumes: Inputs change on the falling clock edge
// Notes:   Every wait is a fixed, bounded loop
`timescale 1ns/1ps
module ets_signal_core_tb;
    logic clk = 1'h0, rst = 1'h1, mc = 1'h0, ie = 1'h0, pf = 1'h0;
    logic tmax = 1'h0, trip = 1'h0, en = 1'h0, hot = 1'h0;
    logic ohn, od, oe, fe, ts, rf, tc, hx;
    int   fails = 0;
    int   checked = 0;

    // Free-running 250 MHz clock
    always #2 clk = ~clk;

    ets_signal_core ets_signal_core_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_machine_check_fault(mc),
        .i_internal_fault(ie), .i_power_fault(pf), .i_temp_max_reached(tmax), .i_trip_over_limit(trip),
        .i_throttle_enable(en), .i_overheat_n(ohn), .o_overheat_n(od), .o_overheat_oe_n(oe),
        .o_fatal_error_n(fe), .o_thermal_shutdown_n(ts), .o_regulator_fault(rf),
        .o_thermal_throttle_circuit(tc), .o_halt_execution(hx));

    ets_platform_model ets_platform_model_i (.i_dev_data(od), .i_dev_oe_n(oe), .i_force_hot(hot),
        .o_wire_n(ohn));

    // Compare and count
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Reset held three cycles; clears sticky state
    task automatic do_rst();
        @(negedge clk) rst = 1'h1;
        repeat (3) @(negedge clk);
        rst = 1'h0;
    endtask

    // Pulse length with a retrigger attempt in mid-pulse
    task automatic t_mc();
        logic [7:0] n;
        n = 8'h00;
        @(negedge clk) mc = 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            mc = (i == 6);
            if (fe === 1'h0) n++;
        end
        chk(8'h10, n);
        chk(8'h01, fe);
    endtask

    // Internal fault holds until reset, beats a machine check, and ends a running pulse
    task automatic t_ie();
        for (int k = 0; k < 2; k++) begin
            @(negedge clk) begin
                ie = (k == 0);
                mc = 1'h1;
            end
            @(negedge clk) begin
                ie = (k == 1);
                mc = 1'h0;
            end
            @(negedge clk) ie = 1'h0;
            repeat (30) @(negedge clk);
            chk(8'h00, fe);
            do_rst();
            chk(8'h01, fe);
        end
    endtask

    // Sensor level drives the pin and throttle, without latching
    task automatic t_hot();
        for (int e = 0; e < 2; e++) begin
            @(negedge clk) begin
                en = e[0];
                tmax = 1'h1;
            end
            #1 chk({6'h00, e[0], 1'h0}, {tc, oe});
            chk(8'h00, {od, ohn});
            @(negedge clk) tmax = 1'h0;
            #1 chk(8'h01, {tc, oe});
        end
    endtask

    // Platform pulls the pin low while device is idle; throttle needs the enable
    task automatic t_ext();
        @(negedge clk) hot = 1'h1;
        #1 chk(8'h03, {tc, oe});
        @(negedge clk) hot = 1'h0;
        #1 chk(8'h00, tc);
        @(negedge clk) begin
            en = 1'h0;
            hot = 1'h1;
        end
        #1 chk(8'h00, tc);
        @(negedge clk) hot = 1'h0;
        #1 chk(8'h01, ohn);
    endtask

    // Trip halts and latches until reset; power fault adds regulator flag
    task automatic t_trip(input logic pwr);
        @(negedge clk) begin
            trip = !pwr;
            pf = pwr;
        end
        @(negedge clk) {trip, pf} = 2'h0;
        repeat (5) @(negedge clk);
        chk({5'h00, pwr, 2'h1}, {rf, ts, hx});
        do_rst();
        chk(8'h02, {rf, ts, hx});
    endtask

    // Counts, then the verdict
    task automatic summarize();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'h0;
        t_mc();
        t_ie();
        t_hot();
        t_ext();
        t_trip(1'h0);
        t_trip(1'h1);
        summarize();
    end
endmodule
